// *** sad_decoder.v ***
// System address decoder: steers each internal-bus access to at most one target.
// Assumes one request per cycle from the master, answered by the chosen target.
`timescale 1ns/10ps
`include "sad_map.vh"
module sad_decoder #(
	parameter SDRAM_AW = 28
) (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// Select bit write from the expansion configuration register zero
	input wire cfg_wr,
	input wire [31:0] cfg_wdata,
	output wire mem_map_sel,
	// Master request
	input wire req_valid,
	input wire [31:0] req_addr,
	// Target selects
	output wire sel_sdram,
	output wire sel_exp,
	output wire sel_pci_data,
	output wire sel_qmgr,
	output wire sel_pci_csr,
	output wire sel_exp_csr,
	output wire [11:0] sel_periph,
	output wire sel_sdram_csr,
	// Address handed to the SDRAM controller
	output wire [31:0] sdram_addr,
	// Reserved-range answer
	output reg err_resp_r
);
	// Single-bit selects, by their place in single_sel.
	localparam N_SINGLE = 7;
	localparam IDX_SDRAM = 0;
	localparam IDX_EXP = 1;
	localparam IDX_PCI_DATA = 2;
	localparam IDX_QMGR = 3;
	localparam IDX_PCI_CSR = 4;
	localparam IDX_EXP_CSR = 5;
	localparam IDX_SDRAM_CSR = 6;
	// Peripheral pages that name a unit; the pages above them are reserved.
	localparam N_PERIPH = 12;

	reg mem_map_r;
	wire [3:0] target;
	wire [3:0] periph_idx;
	wire [N_SINGLE-1:0] single_sel;
	wire any_sel;
	genvar i;

	// Decode map, by address range:
	//   0x0000_0000 to 0x0fff_ffff: expansion bus or SDRAM, by the select bit.
	//   0x1000_0000 to 0x2fff_ffff: SDRAM, whatever the select bit holds.
	//   0x3000_0000 to 0x47ff_ffff: reserved.
	//   0x4800_0000 to 0x4fff_ffff: PCI data.
	//   0x5000_0000 to 0x5fff_ffff: expansion bus data.
	//   0x6000_0000 to 0x63ff_ffff: queue manager.
	//   0x6400_0000 to 0xbfff_ffff: reserved.
	//   0xc000_0000 to 0xc3ff_ffff: PCI controller registers.
	//   0xc400_0000 to 0xc7ff_ffff: expansion bus controller registers.
	//   0xc800_0000 to 0xc800_bfff: one 4KB page per peripheral.
	//   0xc800_c000 to 0xcbff_ffff: reserved.
	//   0xcc00_0000 to 0xcc00_00ff: SDRAM controller registers.
	//   0xcc00_0100 to 0xffff_ffff: reserved.
	// Peripheral pages, by bit of sel_periph:
	//   Bit 0 is the fast UART.
	//   Bit 1 is the console UART.
	//   Bit 2 is the bus performance monitor.
	//   Bit 3 is the interrupt controller.
	//   Bit 4 is the GPIO block.
	//   Bit 5 is the timer block.
	//   Bits 6 to 8 are the three network engines.
	//   Bits 9 and 10 are the two Ethernet MACs.
	//   Bit 11 is the USB device.
	// The top four address bits pick the region in one step; finer cuts inside a region
	// compare only the bits that its boundary needs, which keeps the lookup shallow.

	// Target code served by each single select line.
	function [3:0] single_code;
		input integer k;
		case (k)
			IDX_SDRAM: single_code = `SAD_TGT_SDRAM;
			IDX_EXP: single_code = `SAD_TGT_EXP;
			IDX_PCI_DATA: single_code = `SAD_TGT_PCI_DATA;
			IDX_QMGR: single_code = `SAD_TGT_QMGR;
			IDX_PCI_CSR: single_code = `SAD_TGT_PCI_CSR;
			IDX_EXP_CSR: single_code = `SAD_TGT_EXP_CSR;
			IDX_SDRAM_CSR: single_code = `SAD_TGT_SDRAM_CSR;
			default: single_code = `SAD_TGT_NONE;
		endcase
	endfunction

	// True when a live request decodes to the given target code.
	function hits;
		input valid;
		input [3:0] tgt;
		input [3:0] code;
		hits = valid && tgt == code;
	endfunction

	// Keeps the fitted low bits and clears the rest.
	// A bit loop rather than a replication stays legal when the fitted size fills 32 bits.
	function [31:0] alias_addr;
		input [31:0] a;
		integer b;
		for (b = 0; b < 32; b = b + 1)
			alias_addr[b] = (b < SDRAM_AW) ? a[b] : 1'b0;
	endfunction

	always @(posedge sys_clk) begin
		if (sys_rst)
			mem_map_r <= `SAD_MEM_MAP_RST;
		else if (cfg_wr)
			mem_map_r <= cfg_wdata[`SAD_MEM_MAP_BIT];
	end
	assign mem_map_sel = mem_map_r;

	sad_region u_region (
		.addr(req_addr),
		.low_is_exp(mem_map_r),
		.target(target),
		.periph_sel(periph_idx)
	);

	// one select per target
	// Each line depends on one code only, so a new target costs one table entry.
	generate
		for (i = 0; i < N_SINGLE; i = i + 1) begin : g_single
			assign single_sel[i] = hits(req_valid, target, single_code(i));
		end
	endgenerate
	assign sel_sdram = single_sel[IDX_SDRAM];
	assign sel_exp = single_sel[IDX_EXP];
	assign sel_pci_data = single_sel[IDX_PCI_DATA];
	assign sel_qmgr = single_sel[IDX_QMGR];
	assign sel_pci_csr = single_sel[IDX_PCI_CSR];
	assign sel_exp_csr = single_sel[IDX_EXP_CSR];
	assign sel_sdram_csr = single_sel[IDX_SDRAM_CSR];

	generate
		for (i = 0; i < N_PERIPH; i = i + 1) begin : g_periph
			localparam [31:0] IDX = i;
			assign sel_periph[i] = hits(req_valid, target, `SAD_TGT_PERIPH) &&
				{28'h0000000, periph_idx} == IDX;
		end
	endgenerate

	// drop bits above fitted size
	// Every alias of a byte reaches the same cell, so all of the memory stays reachable.
	assign sdram_addr = alias_addr(req_addr);

	// reserved gives one-cycle error
	// A registered error keeps the bus from waiting on a target that never answers.
	// Keying it on the absence of any select leaves no access between two targets.
	assign any_sel = |single_sel || |sel_periph;
	always @(posedge sys_clk) begin
		if (sys_rst)
			err_resp_r <= 1'b0;
		else
			err_resp_r <= req_valid && !any_sel;
	end
endmodule // sad_decoder

// *** sad_map.vh ***
// Address map constants for the system address decoder.
// Assumes a 32-bit byte address on the internal bus.
`ifndef SAD_MAP_VH
`define SAD_MAP_VH

// Target codes.
`define SAD_TGT_NONE 4'h0
`define SAD_TGT_SDRAM 4'h1
`define SAD_TGT_EXP 4'h2
`define SAD_TGT_PCI_DATA 4'h3
`define SAD_TGT_QMGR 4'h4
`define SAD_TGT_PCI_CSR 4'h5
`define SAD_TGT_EXP_CSR 4'h6
`define SAD_TGT_PERIPH 4'h7
`define SAD_TGT_SDRAM_CSR 4'h8

// Region bounds by top address nibble, byte, six bits, 16 bits or 24 bits.
`define SAD_NIB_LOW 4'h0
`define SAD_NIB_SDRAM_HI 4'h2
`define SAD_NIB_PCI_DATA 4'h4
`define SAD_NIB_EXP_DATA 4'h5
`define SAD_NIB_QMGR 4'h6
`define SAD_BYTE_PCI_DATA 8'h48
`define SAD_BYTE_QMGR_END 8'h63
`define SAD_TOP6_PCI_CSR 6'h30
`define SAD_TOP6_EXP_CSR 6'h31
`define SAD_PERIPH_HI 16'hc800
`define SAD_PERIPH_LAST 4'hb
`define SAD_SDRAM_CSR_HI 24'hcc0000

// Select bit position and its reset value.
`define SAD_MEM_MAP_BIT 31
`define SAD_MEM_MAP_RST 1'b1

`endif

// *** sad_region.v ***
// Combinational region lookup of one 32-bit address.
// Assumes the low-region select level comes from a register in the parent.
`timescale 1ns/10ps
`include "sad_map.vh"
module sad_region (
	// Address and map select
	input wire [31:0] addr,
	input wire low_is_exp,
	// Result
	output reg [3:0] target,
	output reg [3:0] periph_sel
);
	always @* begin
		target = `SAD_TGT_NONE;
		periph_sel = 4'h0;
		case (addr[31:28])
			`SAD_NIB_LOW: target = low_is_exp ? `SAD_TGT_EXP : `SAD_TGT_SDRAM;
			4'h1, `SAD_NIB_SDRAM_HI: target = `SAD_TGT_SDRAM;
			`SAD_NIB_PCI_DATA: begin
				if (addr[31:24] >= `SAD_BYTE_PCI_DATA)
					target = `SAD_TGT_PCI_DATA;
			end
			`SAD_NIB_EXP_DATA: target = `SAD_TGT_EXP;
			`SAD_NIB_QMGR: begin
				if (addr[31:24] <= `SAD_BYTE_QMGR_END)
					target = `SAD_TGT_QMGR;
			end
			4'hc: begin
				if (addr[31:26] == `SAD_TOP6_PCI_CSR)
					target = `SAD_TGT_PCI_CSR;
				else if (addr[31:26] == `SAD_TOP6_EXP_CSR)
					target = `SAD_TGT_EXP_CSR;
				else if (addr[31:16] == `SAD_PERIPH_HI && addr[15:12] <= `SAD_PERIPH_LAST) begin
					target = `SAD_TGT_PERIPH;
					periph_sel = addr[15:12];
				end else if (addr[31:8] == `SAD_SDRAM_CSR_HI)
					target = `SAD_TGT_SDRAM_CSR;
			end
			default: target = `SAD_TGT_NONE;
		endcase
	end
endmodule // sad_region

// *** sad_monitor.sv ***
// Port checker for the address decoder.
// Assumes it is bound to sad_decoder.
`timescale 1ns/10ps
module sad_monitor (
	input logic sys_clk, sys_rst, mem_map_sel, req_valid, err_resp_r,
	input logic [31:0] req_addr,
	input logic sel_sdram, sel_exp, sel_pci_csr,
	input logic [11:0] sel_periph
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire v = req_valid;
	wire [3:0] n = req_addr[31:28];
	a_low_exp: assert property (v && n == 4'h0 && mem_map_sel |-> sel_exp && !sel_sdram)
		else $error("low region missed expansion");
	a_low_sdram: assert property (v && n == 4'h0 && !mem_map_sel |-> sel_sdram && !sel_exp)
		else $error("low region missed sdram");
	a_mid_sdram: assert property (v && (n == 4'h1 || n == 4'h2) |-> sel_sdram)
		else $error("mid region missed sdram");
	a_exp_win: assert property (v && n == 4'h5 |-> sel_exp)
		else $error("expansion window missed");
	a_map_rst: assert property ($fell(sys_rst) |-> mem_map_sel)
		else $error("select bit low after reset");
	a_pci_csr: assert property (v && req_addr[31:26] == 6'h30 |-> sel_pci_csr)
		else $error("pci registers missed");
	a_periph_page: assert property (v && req_addr[31:16] == 16'hc800 && req_addr[15:12] < 4'hc
		|-> sel_periph == 12'h1 << req_addr[15:12])
		else $error("wrong peripheral page");
	a_rsv_err: assert property (v && n == 4'h3 |=> err_resp_r)
		else $error("reserved access without error");
	cover property (err_resp_r);
	cover property (v && n == 4'h0 && sel_exp);
	cover property (v && |sel_periph);
endmodule // sad_monitor

// *** sad_master.sv ***
// Internal bus master model, one request per cycle.
// Assumes its tasks are called at a rising clock edge.
`timescale 1ns/10ps
module sad_master (
	input logic sys_clk,
	output logic req_valid = 1'b0,
	output logic [31:0] req_addr = 32'h0
);
	task drive(input logic [31:0] a);
		req_valid <= 1'b1;
		req_addr <= a;
	endtask
	// A released address shows its inverse so a stale value never decodes.
	task idle;
		req_valid <= 1'b0;
		req_addr <= ~req_addr;
	endtask
endmodule // sad_master

// *** test_system_address_decoder.sv ***
// Self-checking bench for the address decoder.
// Assumes the decoder, master model and checker are compiled first.
`timescale 1ns/10ps
bind sad_decoder sad_monitor mon (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.mem_map_sel(mem_map_sel), .req_valid(req_valid), .err_resp_r(err_resp_r),
	.req_addr(req_addr), .sel_sdram(sel_sdram), .sel_exp(sel_exp),
	.sel_pci_csr(sel_pci_csr), .sel_periph(sel_periph));
module test_system_address_decoder;
	localparam AW = 24;
	logic sys_clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0, mp = 1'b1;
	logic [31:0] cfg_wdata = 32'h0, sdram_addr, req_addr, a;
	logic req_valid, mem_map_sel, err_resp_r, sel_sdram, sel_exp, sel_pci_data, sel_qmgr;
	logic sel_pci_csr, sel_exp_csr, sel_sdram_csr;
	logic [11:0] sel_periph;
	logic [31:0] ed [8] = '{32'hcc0000ff, 32'hcc000100, 32'h47ffffff, 32'h48000000,
		32'h63ffffff, 32'h64000000, 32'hc3ffffff, 32'hc7ffffff};
	int fails = 0, num_checks = 0, i;
	wire [18:0] sels = {sel_sdram, sel_exp, sel_pci_data, sel_qmgr, sel_pci_csr, sel_exp_csr,
		sel_periph, sel_sdram_csr};
	always #5 sys_clk = ~sys_clk;
	sad_master m (.sys_clk(sys_clk), .req_valid(req_valid), .req_addr(req_addr));
	sad_decoder #(.SDRAM_AW(AW)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr),
		.cfg_wdata(cfg_wdata), .mem_map_sel(mem_map_sel), .req_valid(req_valid),
		.req_addr(req_addr), .sel_sdram(sel_sdram), .sel_exp(sel_exp),
		.sel_pci_data(sel_pci_data), .sel_qmgr(sel_qmgr), .sel_pci_csr(sel_pci_csr),
		.sel_exp_csr(sel_exp_csr), .sel_periph(sel_periph), .sel_sdram_csr(sel_sdram_csr),
		.sdram_addr(sdram_addr), .err_resp_r(err_resp_r));
	function logic [18:0] exp_sel(input logic [31:0] x, input logic p);
		exp_sel = 19'h0;
		if (x[31:28] == 4'h0) exp_sel[p ? 17 : 18] = 1'b1;
		else if (x[31:28] < 4'h3) exp_sel[18] = 1'b1;
		else if (x[31:27] == 5'h09) exp_sel[16] = 1'b1;
		else if (x[31:28] == 4'h5) exp_sel[17] = 1'b1;
		else if (x[31:26] == 6'h18) exp_sel[15] = 1'b1;
		else if (x[31:26] == 6'h30) exp_sel[14] = 1'b1;
		else if (x[31:26] == 6'h31) exp_sel[13] = 1'b1;
		else if (x[31:16] == 16'hc800 && x[15:12] < 4'hc) exp_sel[1 + x[15:12]] = 1'b1;
		else if (x[31:8] == 24'hcc0000) exp_sel[0] = 1'b1;
	endfunction
	task chk(input string nm, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task print_verdict;
		if (fails == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task acc(input logic [31:0] x);
		@(posedge sys_clk);
		m.drive(x);
		#1 chk("selects", exp_sel(x, mp), sels);
		chk("sdram_addr", x & ((32'h1 << AW) - 1), sdram_addr);
		chk("err_resp_r", 0, err_resp_r);
		@(posedge sys_clk);
		m.idle();
		#1 chk("err_resp_r", exp_sel(x, mp) == 19'h0, err_resp_r);
	endtask
	task wr(input logic b);
		@(posedge sys_clk);
		cfg_wr <= 1'b1;
		cfg_wdata <= {b, 31'($urandom)};
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
		mp = b;
		#1 chk("mem_map_sel", b, mem_map_sel);
	endtask
	initial begin
		void'($urandom(32'hb687bdcd));
		repeat (12) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1 chk("mem_map_sel", 1, mem_map_sel);
		acc(32'h0);
		for (i = 0; i < 400; i++) begin
			if (i % 16 == 0) wr(~mp);
			a = $urandom;
			if (i < 32) a = {i[4:1], {28{i[0]}}};
			else if (i < 45) a[31:12] = {16'hc800, 4'(i - 32)};
			else if (i < 53) a = ed[i - 45];
			acc(a);
		end
		wr(1'b0);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		mp = 1'b1;
		#1 chk("mem_map_sel", 1, mem_map_sel);
		acc(32'h0);
		print_verdict();
	end
	initial begin
		#300000;
		fails++;
		print_verdict();
	end
endmodule // test_system_address_decoder
